// File: hw/asm_seq_monitor_regs.sv
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
// Function
// RULE1: Upper boundary is a 12-bit read-write field in bits 11:0, reset all ones.
// RULE2: Lower boundary is a 12-bit read-write field in bits 11:0, reset all ones.
// RULE3: Length field at bits 23:20 of first sequence register; n means n+1 conversions.
// RULE4: Each 5-bit slot names the input channel sampled by that conversion.
// RULE5: First sequence register holds slots 13 to 16 in bits 4:0 up to 19:15.
// RULE6: Second sequence register holds slots 7 to 12 in bits 4:0 up to 29:25.
// RULE7: Third sequence register holds slots 1 to 6 in bits 4:0 up to 29:25.
// RULE8: Software writes reserved bits back as zero; hardware keeps them zero anyway.
// RULE9: Conversions run in slot order from slot one, stopping after the chosen count.
// RULE10: Flag an event when a monitored result is above upper or below lower boundary.
module asm_seq_monitor_regs (
	input  wire logic                       mclk,
	input  wire logic                       srst,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic                            convStart,
	output logic      [asm_pkg::CHAN_W-1:0] convChannel,
	input  wire logic                       convDone,
	input  wire logic [asm_pkg::DATA_W-1:0] convResult,
	output logic                            irq
);

	localparam int NS = asm_pkg::SLOTS;
	localparam int CW = asm_pkg::CHAN_W;
	localparam int DW = asm_pkg::DATA_W;
	localparam int LW = asm_pkg::LEN_W;

	// Fields must fit their registers: slots 13 up stop below the length field
	if ((NS - 2 * asm_pkg::SLOTS_PER_REG) * CW > asm_pkg::LEN_LSB)
		$error("asm_seq_monitor_regs: first-register slots overlap the length field");
	if (NS != (1 << LW) || (1 << CW) <= asm_pkg::MAX_CHANNEL)
		$error("asm_seq_monitor_regs: slot count or channel width does not fit");

	// Software registers
	logic [31:0] upper_reg;
	logic [31:0] upper_next;
	logic [31:0] lower_reg;
	logic [31:0] lower_next;
	logic [31:0] seq1_reg;
	logic [31:0] seq1_next;
	logic [31:0] seq2_reg;
	logic [31:0] seq2_next;
	logic [31:0] seq3_reg;
	logic [31:0] seq3_next;
	logic [31:0] intStat_reg;
	logic [31:0] intStat_next;
	logic [31:0] intMask_reg;
	logic [31:0] intMask_next;
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;

	// Observed state
	logic [DW-1:0] lastResult_reg;
	logic [CW-1:0] lastChan_reg;
	logic [CW-1:0] chanHold_reg;

	// Bus output flops
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        pslverr_next;
	logic        convStart_reg;
	logic [CW-1:0] convChannel_reg;
	logic        irq_reg;

	// Bus decode
	logic        setupPhase;
	logic        accessDone;
	logic        wrDone;
	logic        hitUpper;
	logic        hitLower;
	logic        hitSeq1;
	logic        hitSeq2;
	logic        hitSeq3;
	logic        hitIntStat;
	logic        hitIntMask;
	logic        hitCtrl;
	logic        hitStatus;
	logic        hitAny;
	logic [31:0] statusWord;
	logic [31:0] readMux;

	// Sequencer and monitor links
	logic [NS*CW-1:0] slotFlat;
	logic [LW-1:0]    seqLen;
	logic             startPulse;
	logic             seqReq;
	logic [CW-1:0]    seqChannel;
	logic [LW-1:0]    seqIdx;
	logic             seqBusy;
	logic             resultTake;
	logic             seqEnd;
	logic             outside;
	logic             monitorEvent;
	logic [31:0]      eventSet;

	// Phase decode: answer comes in the access cycle after every setup
	assign setupPhase = psel && !penable;
	assign accessDone = psel && penable && pready_reg;
	assign wrDone     = accessDone && pwrite;

	// Address decode
	assign hitUpper   = (paddr == asm_pkg::OFF_UPPER);
	assign hitLower   = (paddr == asm_pkg::OFF_LOWER);
	assign hitSeq1    = (paddr == asm_pkg::OFF_SEQ1);
	assign hitSeq2    = (paddr == asm_pkg::OFF_SEQ2);
	assign hitSeq3    = (paddr == asm_pkg::OFF_SEQ3);
	assign hitIntStat = (paddr == asm_pkg::OFF_INTSTAT);
	assign hitIntMask = (paddr == asm_pkg::OFF_INTMASK);
	assign hitCtrl    = (paddr == asm_pkg::OFF_CTRL);
	assign hitStatus  = (paddr == asm_pkg::OFF_STATUS);
	assign hitAny     = hitUpper | hitLower | hitSeq1 | hitSeq2 | hitSeq3
	                  | hitIntStat | hitIntMask | hitCtrl | hitStatus;

	// Live status word: last result, its channel, slot in progress, busy
	assign statusWord = {7'h00,
	                     seqBusy,
	                     3'h0,
	                     seqIdx,
	                     lastChan_reg,
	                     lastResult_reg};

	// Read selection; unmapped addresses read zero
	assign readMux = hitUpper   ? upper_reg   :
	                 hitLower   ? lower_reg   :
	                 hitSeq1    ? seq1_reg    :
	                 hitSeq2    ? seq2_reg    :
	                 hitSeq3    ? seq3_reg    :
	                 hitIntStat ? intStat_reg :
	                 hitIntMask ? intMask_reg :
	                 hitCtrl    ? ctrl_reg    :
	                 hitStatus  ? statusWord  : 32'h0000_0000;

	// Read data and error are captured in setup so the outputs stay flops
	assign prdata_next  = (setupPhase && !pwrite) ? readMux : prdata_reg;
	assign pslverr_next = setupPhase ? !hitAny : (pslverr_reg && !accessDone);

	// Register writes; masks force reserved bits to stay zero
	assign upper_next = (wrDone && hitUpper) ? (pwdata & asm_pkg::MASK_BOUND) : upper_reg; // RULE1 RULE8
	assign lower_next = (wrDone && hitLower) ? (pwdata & asm_pkg::MASK_BOUND) : lower_reg; // RULE2 RULE8
	assign seq1_next  = (wrDone && hitSeq1) ? (pwdata & asm_pkg::MASK_SEQ1) : seq1_reg; // RULE3 RULE5 RULE8
	assign seq2_next  = (wrDone && hitSeq2) ? (pwdata & asm_pkg::MASK_SEQ23) : seq2_reg; // RULE6 RULE8
	assign seq3_next  = (wrDone && hitSeq3) ? (pwdata & asm_pkg::MASK_SEQ23) : seq3_reg; // RULE7 RULE8
	assign intMask_next = (wrDone && hitIntMask) ? (pwdata & asm_pkg::MASK_INT) : intMask_reg;
	assign ctrl_next    = (wrDone && hitCtrl) ? (pwdata & asm_pkg::MASK_CTRL) : ctrl_reg;

	// Start is a write-one strobe, never stored, so reads of it give zero
	assign startPulse = wrDone && hitCtrl && pwdata[asm_pkg::CTRL_START];

	// Length field of the first sequence register
	assign seqLen = seq1_reg[asm_pkg::LEN_LSB +: LW]; // RULE3

	// Slots 1-6 in the third register, 7-12 in the second, 13-16 in the first
	for (genvar s = 0; s < NS; s++) begin : g_slot
		localparam int POS = (s % asm_pkg::SLOTS_PER_REG) * CW;
		if (s < asm_pkg::SLOTS_PER_REG) begin : g_third
			assign slotFlat[s*CW +: CW] = seq3_reg[POS +: CW]; // RULE7
		end else if (s < 2 * asm_pkg::SLOTS_PER_REG) begin : g_second
			assign slotFlat[s*CW +: CW] = seq2_reg[POS +: CW]; // RULE6
		end else begin : g_first
			assign slotFlat[s*CW +: CW] = seq1_reg[POS +: CW]; // RULE5
		end
	end

	// Conversion order
	asm_sequencer #(
		.SLOTS (NS),
		.CHW   (CW),
		.LENW  (LW)
	) u_seq (
		.mclk       (mclk),
		.srst       (srst),
		.start      (startPulse),
		.slots      (slotFlat),
		.seqLen     (seqLen),
		.convDone   (convDone),
		.reqValid   (seqReq),
		.reqChannel (seqChannel),
		.slotIdx    (seqIdx),
		.busy       (seqBusy),
		.resultTake (resultTake),
		.seqEnd     (seqEnd)
	);

	// Boundary compare on the incoming result
	asm_monitor #(
		.DW (DW)
	) u_mon (
		.result     (convResult),
		.upperBound (upper_reg[DW-1:0]),
		.lowerBound (lower_reg[DW-1:0]),
		.outside    (outside)
	);

	// Only results the sequencer accepts, and only with monitoring on
	assign monitorEvent = resultTake && ctrl_reg[asm_pkg::CTRL_MON_EN] && outside; // RULE10

	// Sticky events; a set in the clearing cycle wins over the clear
	assign eventSet = {30'h0000_0000, seqEnd, monitorEvent};
	assign intStat_next = eventSet
	                    | (intStat_reg & ~((wrDone && hitIntStat) ? pwdata : 32'h0000_0000));

	// Upper boundary; reserved bits never load, so reads of them stay zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			upper_reg <= asm_pkg::RST_BOUND; // RULE1
		end else begin
			upper_reg <= upper_next;
		end
	end

	// Lower boundary
	always_ff @(posedge mclk) begin
		if (srst) begin
			lower_reg <= asm_pkg::RST_BOUND; // RULE2
		end else begin
			lower_reg <= lower_next;
		end
	end

	// First sequence register: length and slots 13 to 16
	always_ff @(posedge mclk) begin
		if (srst) begin
			seq1_reg <= asm_pkg::RST_SEQ; // RULE3
		end else begin
			seq1_reg <= seq1_next;
		end
	end

	// Second sequence register: slots 7 to 12
	always_ff @(posedge mclk) begin
		if (srst) begin
			seq2_reg <= asm_pkg::RST_SEQ; // RULE6
		end else begin
			seq2_reg <= seq2_next;
		end
	end

	// Third sequence register: slots 1 to 6
	always_ff @(posedge mclk) begin
		if (srst) begin
			seq3_reg <= asm_pkg::RST_SEQ; // RULE7
		end else begin
			seq3_reg <= seq3_next;
		end
	end

	// Sticky event flags; the set term wins over a same-cycle clear so no event is lost
	always_ff @(posedge mclk) begin
		if (srst) begin
			intStat_reg <= asm_pkg::RST_ZERO;
		end else begin
			intStat_reg <= intStat_next;
		end
	end

	// Interrupt mask
	always_ff @(posedge mclk) begin
		if (srst) begin
			intMask_reg <= asm_pkg::RST_ZERO;
		end else begin
			intMask_reg <= intMask_next;
		end
	end

	// Control; only the monitor enable is stored
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_reg <= asm_pkg::RST_ZERO;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Interrupt line from next values, so it moves with the status flops and not a cycle later
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(intStat_next & intMask_next);
		end
	end

	// Read data, captured in setup and held until the next read
	always_ff @(posedge mclk) begin
		if (srst) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	// Ready follows every setup by one cycle: no wait states, one access per setup
	always_ff @(posedge mclk) begin
		if (srst) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= setupPhase;
		end
	end

	// Error flag, high only in the access cycle of an unmapped transfer
	always_ff @(posedge mclk) begin
		if (srst) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= pslverr_next;
		end
	end

	// Converter request; channel held from request until the result returns
	always_ff @(posedge mclk) begin
		if (srst) begin
			convStart_reg   <= 1'b0;
			convChannel_reg <= '0;
			chanHold_reg    <= '0;
		end else begin
			convStart_reg <= seqReq; // RULE9
			if (seqReq) begin
				convChannel_reg <= seqChannel; // RULE4
				chanHold_reg    <= seqChannel;
			end
		end
	end

	// Last accepted result, for software to see
	always_ff @(posedge mclk) begin
		if (srst) begin
			lastResult_reg <= '0;
			lastChan_reg   <= '0;
		end else if (resultTake) begin
			lastResult_reg <= convResult;
			lastChan_reg   <= chanHold_reg;
		end
	end

	// Outputs
	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign convStart   = convStart_reg;
	assign convChannel = convChannel_reg;
	assign irq         = irq_reg;

endmodule // asm_seq_monitor_regs

// File: hw/asm_pkg.sv
package asm_pkg;

	// Widths of the converter fields
	localparam int DATA_W  = 12;
	localparam int CHAN_W  = 5;
	localparam int LEN_W   = 4;
	localparam int SLOTS   = 16;
	localparam int MAX_CHANNEL = 17;

	// Register byte addresses on the bus
	localparam logic [7:0] OFF_UPPER   = 8'h00;
	localparam logic [7:0] OFF_LOWER   = 8'h04;
	localparam logic [7:0] OFF_SEQ1    = 8'h08;
	localparam logic [7:0] OFF_SEQ2    = 8'h0C;
	localparam logic [7:0] OFF_SEQ3    = 8'h10;
	localparam logic [7:0] OFF_INTSTAT = 8'h14;
	localparam logic [7:0] OFF_INTMASK = 8'h18;
	localparam logic [7:0] OFF_CTRL    = 8'h1C;
	localparam logic [7:0] OFF_STATUS  = 8'h20;

	// Values after reset
	localparam logic [31:0] RST_BOUND = 32'h0000_0FFF;
	localparam logic [31:0] RST_SEQ   = 32'h0000_0000;
	localparam logic [31:0] RST_ZERO  = 32'h0000_0000;

	// Writable bits; everything else is reserved and reads zero
	localparam logic [31:0] MASK_BOUND = 32'h0000_0FFF;
	localparam logic [31:0] MASK_SEQ1  = 32'h00FF_FFFF;
	localparam logic [31:0] MASK_SEQ23 = 32'h3FFF_FFFF;
	localparam logic [31:0] MASK_INT   = 32'h0000_0003;
	localparam logic [31:0] MASK_CTRL  = 32'h0000_0002;

	// Field positions
	localparam int LEN_LSB       = 20;
	localparam int SLOTS_PER_REG = 6;
	localparam int INT_MONITOR   = 0;
	localparam int INT_SEQDONE   = 1;
	localparam int CTRL_START    = 0;
	localparam int CTRL_MON_EN   = 1;
	localparam int ST_RESULT_LSB = 0;
	localparam int ST_CHAN_LSB   = 12;
	localparam int ST_IDX_LSB    = 17;
	localparam int ST_BUSY       = 24;

endpackage

// File: hw/asm_monitor.sv
`timescale 1ns/100ps
module asm_monitor #(
	parameter int DW = 12
) (
	input  wire logic [DW-1:0] result,
	input  wire logic [DW-1:0] upperBound,
	input  wire logic [DW-1:0] lowerBound,
	output logic               outside
);

	// Strict compares: a result equal to a boundary is still inside
	assign outside = (result > upperBound) || (result < lowerBound); // RULE10

endmodule // asm_monitor

// File: hw/asm_sequencer.sv
`timescale 1ns/100ps
module asm_sequencer #(
	parameter int SLOTS = 16,
	parameter int CHW   = 5,
	parameter int LENW  = 4
) (
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  start,
	input  wire logic [SLOTS*CHW-1:0]  slots,
	input  wire logic [LENW-1:0]       seqLen,
	input  wire logic                  convDone,
	output logic                       reqValid,
	output logic [CHW-1:0]             reqChannel,
	output logic [LENW-1:0]            slotIdx,
	output logic                       busy,
	output logic                       resultTake,
	output logic                       seqEnd
);

	typedef enum logic [1:0] {SQ_IDLE, SQ_REQ, SQ_WAIT} asm_seq_state_t;

	asm_seq_state_t  state_reg;
	asm_seq_state_t  state_next;
	logic [LENW-1:0] idx_reg;
	logic [LENW-1:0] idx_next;
	logic            lastSlot;

	// The slot index must cover every slot exactly
	if (SLOTS != (1 << LENW))
		$error("asm_sequencer: SLOTS must equal 2**LENW");

	// Channel of the slot in progress
	assign reqChannel = slots[idx_reg*CHW +: CHW]; // RULE4
	assign lastSlot   = (idx_reg == seqLen);
	assign reqValid   = (state_reg == SQ_REQ);
	assign resultTake = (state_reg == SQ_WAIT) && convDone;
	assign seqEnd     = resultTake && lastSlot;
	assign busy       = (state_reg != SQ_IDLE);
	assign slotIdx    = idx_reg;

	// Walk the slots from the first; a start while busy is ignored
	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		case (state_reg)
			SQ_IDLE: begin
				if (start) begin
					idx_next   = '0; // RULE9
					state_next = SQ_REQ;
				end
			end
			SQ_REQ: begin
				state_next = SQ_WAIT;
			end
			SQ_WAIT: begin
				if (convDone) begin
					if (lastSlot) begin
						state_next = SQ_IDLE; // RULE9
					end else begin
						idx_next   = idx_reg + 1'b1; // RULE9
						state_next = SQ_REQ;
					end
				end
			end
			default: begin
				state_next = SQ_IDLE;
			end
		endcase
	end

	// State flops
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= SQ_IDLE;
			idx_reg   <= '0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
		end
	end

endmodule // asm_sequencer

// File: sim/asm_seq_monitor_regs_properties.sv
`timescale 1ns/100ps
// Watches bus answers, reserved bits and converter requests
module asm_seq_monitor_regs_chk (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        convStart,
	input wire logic [4:0]  convChannel,
	input wire logic        convDone,
	input wire logic [11:0] convResult,
	input wire logic        irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// Zero wait states, one ready per setup
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ready_has_setup: assert property (pready |-> $past(psel && !penable))
		else $error("ready without setup");
	a_unmapped_error: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h20))
		else $error("error flag does not match address");

	// Reserved bits always read zero
	a_bound_reserved: assert property (pready && !pwrite && paddr <= 8'h04 |-> prdata[31:12] == 20'h0_0000)
		else $error("boundary reserved bits set");
	a_seq_reserved: assert property (pready && !pwrite && paddr inside {8'h08, 8'h0C, 8'h10}
		|-> prdata[31:30] == 2'h0 && (paddr != 8'h08 || prdata[31:24] == 8'h00))
		else $error("sequence reserved bits set");

	// A request lasts one cycle and has a cause two cycles back
	a_start_pulse: assert property (convStart |=> !convStart)
		else $error("start longer than one cycle");
	a_start_cause: assert property (convStart |-> $past(convDone, 2)
		|| $past(psel && penable && pready && pwrite && paddr == 8'h1C && pwdata[0], 2))
		else $error("start without trigger");
	a_chan_with_start: assert property ($changed(convChannel) |-> convStart)
		else $error("channel moved without start");
endmodule // asm_seq_monitor_regs_chk

bind asm_seq_monitor_regs asm_seq_monitor_regs_chk i_chk (.mclk(mclk), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .convStart(convStart), .convChannel(convChannel),
	.convDone(convDone), .convResult(convResult), .irq(irq));

// File: sim/asm_seq_monitor_regs_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the sequence and monitor register bank
module asm_seq_monitor_regs_bench;
	logic        mclk       = 1'b0;
	logic        srst       = 1'b1;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0000_0000;
	logic        convDone   = 1'b0;
	logic [11:0] convResult = 12'h000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        convStart;
	logic [4:0]  convChannel;
	logic        irq;
	int          errTotal   = 0;
	int          nTests     = 0;

	// Bus clock, 50 ns period
	always #25 mclk = ~mclk;

	asm_seq_monitor_regs i_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .convStart(convStart), .convChannel(convChannel),
		.convDone(convDone), .convResult(convResult), .irq(irq));

	// Compare and count
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// One transfer; the wait for ready is bounded so a dead slave ends the run
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		check("pready", 32'(pready), 32'h0000_0001);
		if (pready !== 1'b1) endOfTest();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		check(name, rd, exp);
	endtask

	// Distinct channels per slot, slot five names the top channel
	function automatic logic [4:0] chanOf(input int k);
		return 5'((k * 7) % 18);
	endfunction

	// Load slots, start, answer each request at once, then look at the end state
	task automatic runSeq(input logic [3:0] len, input logic [11:0] res, input logic [31:0] ctrl,
		input logic [31:0] expSt);
		logic [31:0] s1;
		logic [31:0] s2;
		logic [31:0] s3;
		logic [31:0] expStat;
		int          n;
		s1 = {8'h00, len, 20'h0_0000};
		s2 = 32'h0000_0000;
		s3 = 32'h0000_0000;
		for (int k = 1; k <= 16; k++) begin
			if (k <= 6) s3 |= 32'(chanOf(k)) << (5 * (k - 1));
			else if (k <= 12) s2 |= 32'(chanOf(k)) << (5 * (k - 7));
			else s1 |= 32'(chanOf(k)) << (5 * (k - 13));
		end
		wr(asm_pkg::OFF_SEQ1, s1);
		wr(asm_pkg::OFF_SEQ2, s2);
		wr(asm_pkg::OFF_SEQ3, s3);
		wr(asm_pkg::OFF_INTSTAT, 32'h0000_0003);
		wr(asm_pkg::OFF_CTRL, ctrl);
		for (int k = 1; k <= int'(len) + 1; k++) begin
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (convStart !== 1'b1 && n < 20);
			check("convStart", 32'(convStart), 32'h0000_0001);
			if (convStart !== 1'b1) endOfTest();
			check("convChannel", 32'(convChannel), 32'(chanOf(k)));
			convDone <= 1'b1;
			convResult <= res;
			@(posedge mclk);
			convDone <= 1'b0;
		end
		n = 0;
		repeat (8) begin
			@(posedge mclk);
			if (convStart === 1'b1) n++;
		end
		check("extra starts", 32'(n), 32'h0000_0000);
		rdChk("intStat", asm_pkg::OFF_INTSTAT, expSt);
		expStat = (32'(res) << asm_pkg::ST_RESULT_LSB) | (32'(len) << asm_pkg::ST_IDX_LSB);
		expStat |= 32'(chanOf(int'(len) + 1)) << asm_pkg::ST_CHAN_LSB;
		rdChk("status", asm_pkg::OFF_STATUS, expStat);
	endtask

	task automatic testReset();
		rdChk("upper", asm_pkg::OFF_UPPER, 32'h0000_0FFF);
		rdChk("lower", asm_pkg::OFF_LOWER, 32'h0000_0FFF);
		rdChk("seq1", asm_pkg::OFF_SEQ1, 32'h0000_0000);
		rdChk("seq2", asm_pkg::OFF_SEQ2, 32'h0000_0000);
		rdChk("seq3", asm_pkg::OFF_SEQ3, 32'h0000_0000);
	endtask

	// Every boundary and sequence field written full and read back; reserved bits go out as zero
	task automatic testFields();
		logic [7:0]  a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
		logic [31:0] m[5] = '{32'h0000_0FFF, 32'h0000_0FFF, 32'h00FF_FFFF, 32'h3FFF_FFFF, 32'h3FFF_FFFF};
		for (int i = 0; i < 5; i++) begin
			wr(a[i], m[i]);
			rdChk("readback", a[i], m[i]);
		end
	endtask

	task automatic testUnmapped();
		logic [31:0] rd;
		logic        err;
		apb(1'b0, 8'h40, 32'h0000_0000, rd, err);
		check("unmapped err", 32'(err), 32'h0000_0001);
		check("unmapped data", rd, 32'h0000_0000);
	endtask

	task automatic testSequences();
		runSeq(4'hF, 12'h400, 32'h0000_0001, 32'h0000_0002);
		runSeq(4'h0, 12'h400, 32'h0000_0001, 32'h0000_0002);
	endtask

	// Strict compare: results equal to a boundary raise nothing
	task automatic testMonitor();
		wr(asm_pkg::OFF_UPPER, 32'h0000_0800);
		wr(asm_pkg::OFF_LOWER, 32'h0000_0100);
		runSeq(4'h0, 12'h801, 32'h0000_0003, 32'h0000_0003);
		runSeq(4'h0, 12'h0FF, 32'h0000_0003, 32'h0000_0003);
		runSeq(4'h1, 12'h800, 32'h0000_0003, 32'h0000_0002);
		runSeq(4'h0, 12'h100, 32'h0000_0003, 32'h0000_0002);
		runSeq(4'h0, 12'h900, 32'h0000_0001, 32'h0000_0002);
	endtask

	// Event masked, unmasked, then cleared by writing one
	task automatic testIrq();
		wr(asm_pkg::OFF_INTMASK, 32'h0000_0000);
		runSeq(4'h0, 12'hA00, 32'h0000_0003, 32'h0000_0003);
		rdChk("ctrl", asm_pkg::OFF_CTRL, 32'h0000_0002);
		check("irq masked", 32'(irq), 32'h0000_0000);
		wr(asm_pkg::OFF_INTMASK, 32'h0000_0001);
		repeat (2) @(posedge mclk);
		check("irq raised", 32'(irq), 32'h0000_0001);
		rdChk("intMask", asm_pkg::OFF_INTMASK, 32'h0000_0001);
		wr(asm_pkg::OFF_INTSTAT, 32'h0000_0001);
		repeat (2) @(posedge mclk);
		check("irq cleared", 32'(irq), 32'h0000_0000);
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		testReset();
		testFields();
		testUnmapped();
		testSequences();
		testMonitor();
		testIrq();
		endOfTest();
	end
endmodule // asm_seq_monitor_regs_bench
